/* File: bench/sfd_fetch_model.sv */
module sfd_fetch_model
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Request from the bench
	input  wire logic        go,
	input  wire logic [31:0] word_in,
	// Issue port
	output logic             valid,
	output logic [31:0]      word
);
	timeunit 1ns;
	timeprecision 1ps;
	// Between issues the word is inverted so a stale value never looks valid
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valid <= 1'b0;
			word <= 32'h0;
		end
		else
		begin
			valid <= go;
			word <= go ? word_in : ~word;
		end
	end
endmodule

/* File: bench/sfd_top_sva.sv */
module sfd_top_sva
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RSTN,
	// Instruction and result
	input wire logic        INSTR_VALID,
	input wire logic [31:0] INSTR_WORD,
	input wire logic        DEC_VALID,
	input sfd_op_t          DEC_OP,
	input wire logic        DEC_RESERVED,
	input sfd_class_t       DEC_CLASS
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	wire        iv = INSTR_VALID;
	wire [31:0] w  = INSTR_WORD;
	property p_follow; iv |=> DEC_VALID; endproperty
	a_follow: assert property (p_follow) else $error("no result");
	property p_pulse; !iv |=> !DEC_VALID; endproperty
	a_pulse: assert property (p_pulse) else $error("extra result");
	property p_rsv; DEC_VALID && DEC_RESERVED |-> DEC_OP == OP_NONE;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved with op");
	property p_one; DEC_VALID && !DEC_RESERVED |-> DEC_OP != OP_NONE;
	endproperty
	a_one: assert property (p_one) else $error("no op");
	property p_hold;
		!DEC_VALID |-> $stable(DEC_OP) && $stable(DEC_RESERVED);
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_srl;
		iv && w[31:21] == 11'h0 && w[5:0] == 6'h02
		|=> DEC_OP == OP_SHIFT_RIGHT_LOGICAL;
	endproperty
	a_srl: assert property (p_srl) else $error("bad shift");
	property p_move_on_fp_condition;
		iv && w[31:26] == 6'h00 && w[5:0] == 6'h01 && !w[17] && w[10:6] == 5'h0
		|=> DEC_OP == ($past(INSTR_WORD[16]) ? OP_MOVE_IF_COND_TRUE
			: OP_MOVE_IF_COND_FALSE);
	endproperty
	a_move_on_fp_condition: assert property (p_move_on_fp_condition) else $error("bad move");
	property p_arith;
		iv && w[31:21] == 11'h230 && w[5:3] == 3'h0
		|=> 6'(DEC_OP) == 6'(OP_FP_ADD) + {3'h0, $past(INSTR_WORD[2:0])};
	endproperty
	a_arith: assert property (p_arith) else $error("bad arith");
	property p_cmp;
		iv && w[31:21] == 11'h230 && w[5:4] == 2'h3 && !w[0]
		|=> 6'(DEC_OP) == 6'(OP_FP_CMP_F) + {3'h0, $past(INSTR_WORD[3:1])};
	endproperty
	a_cmp: assert property (p_cmp) else $error("bad compare");
	property p_probe;
		iv && w[31:25] == 7'h21 && w[5:0] == 6'h08
		|=> DEC_OP == OP_TRANSLATION_BUFFER_PROBE;
	endproperty
	a_probe: assert property (p_probe) else $error("bad probe");
	property p_cls; iv && w[31:26] == 6'h11 |=> DEC_CLASS == CLS_FLOATING_POINT_COPROCESSOR;
	endproperty
	a_cls: assert property (p_cls) else $error("bad class");
endmodule
bind sfd_top sfd_top_sva u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
	.DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP),
	.DEC_RESERVED(DEC_RESERVED), .DEC_CLASS(DEC_CLASS));

/* File: bench/test_secondary_field_instr_decoder.sv */
module test_secondary_field_instr_decoder
	import sfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        go = 1'b0;
	logic        ivalid;
	logic        dvalid;
	logic        drsv;
	logic        rel2 = 1'b1;
	logic [31:0] pword = 32'h0;
	logic [31:0] iword;
	logic [31:0] seed = 32'h59E7;
	logic [31:0] rd;
	logic [31:0] w;
	sfd_op_t     dop;
	sfd_class_t  dcls;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	always #5 clk = ~clk;
	sfd_fetch_model u_fetch (.clk(clk), .rst_n(rst_n), .go(go),
		.word_in(pword), .valid(ivalid), .word(iword));
	sfd_top DUT (.CLK_SYS(clk), .RSTN(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .INSTR_VALID(ivalid), .INSTR_WORD(iword),
		.DEC_VALID(dvalid), .DEC_OP(dop), .DEC_RESERVED(drsv),
		.DEC_CLASS(dcls));
	task stop_test();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function sfd_op_t shr_exp(input logic [31:0] x, input logic r2);
		return (r2 && x[21]) ? OP_ROTATE_RIGHT : OP_SHIFT_RIGHT_LOGICAL;
	endfunction
	function sfd_op_t fp_exp(input logic [31:0] x);
		return sfd_op_t'(OP_FP_ADD + x[2:0]);
	endfunction
	task report(input logic ok, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (!ok)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task cmp32(input logic [31:0] g, input logic [31:0] e);
		report(g === e, g, e);
	endtask
	task cmp_op(input sfd_op_t g, input sfd_op_t e);
		report(g === e, 32'(g), 32'(e));
	endtask
	task cmp_bit(input logic g, input logic e);
		report(g === e, 32'(g), 32'(e));
	endtask
	task cmp_cls(input sfd_class_t g, input sfd_class_t e);
		report(g === e, 32'(g), 32'(e));
	endtask
	task test_done(input string s);
		$display("%s done", s);
	endtask
	task reset();
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	// Single AHB-Lite transfer; read data lands in rd
	task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		cmp_bit(hresp, 1'b0);
	endtask
	task mode(input logic [31:0] c);
		bus(1'b1, 32'h0, c);
		rel2 = c[0];
	endtask
	task dec(input logic [31:0] wd, input sfd_op_t e, input logic er);
		@(posedge clk);
		go <= 1'b1;
		pword <= wd;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
		cmp_bit(dvalid, 1'b1);
		cmp_op(dop, e);
		cmp_bit(drsv, er);
	endtask
	initial
	begin
		reset();
		bus(1'b0, 32'h0, 32'h0);
		cmp32(rd, 32'h1);
		bus(1'b0, 32'h10, 32'h0);
		cmp32(rd, 32'h0);
		test_done("registers");
		dec(32'h0020_0002, OP_ROTATE_RIGHT, 1'b0);
		dec(32'h0000_0046, OP_ROTATE_RIGHT_VARIABLE, 1'b0);
		dec(32'h0000_0006, OP_SHIFT_RIGHT_LOGICAL_VARIABLE, 1'b0);
		dec(32'h0000_0001, OP_MOVE_IF_COND_FALSE, 1'b0);
		dec(32'h0001_0001, OP_MOVE_IF_COND_TRUE, 1'b0);
		dec(32'h7C00_00A0, OP_SWAP_BYTES_IN_HALFWORDS, 1'b0);
		dec(32'h7C00_0420, OP_SIGN_EXTEND_BYTE, 1'b0);
		dec(32'h7C00_0620, OP_SIGN_EXTEND_HALFWORD, 1'b0);
		dec(32'h7C00_0060, OP_NO_OPERATION, 1'b0);
		dec(32'h7C00_0008, OP_NONE, 1'b1);
		dec(32'h4160_0000, OP_DISABLE_INTERRUPTS, 1'b0);
		dec(32'h4160_0020, OP_ENABLE_INTERRUPTS, 1'b0);
		dec(32'h0000_0000, OP_NO_OPERATION, 1'b0);
		cmp_cls(dcls, CLS_SPECIAL);
		dec(32'h0000_0040, OP_SUPERSCALAR_NO_OPERATION, 1'b0);
		dec(32'h0000_00C0, OP_EXECUTION_HAZARD_BARRIER, 1'b0);
		dec(32'h0000_0140, OP_PAUSE, 1'b0);
		dec(32'h0000_1080, OP_SHIFT_LEFT_LOGICAL, 1'b0);
		dec(32'h0000_0008, OP_JUMP_REGISTER, 1'b0);
		dec(32'h0000_0408, OP_JUMP_REGISTER_HAZARD_BARRIER, 1'b0);
		dec(32'h0000_0009, OP_JUMP_LINK_REGISTER, 1'b0);
		dec(32'h0000_0409, OP_JUMP_LINK_REGISTER_BARRIER, 1'b0);
		dec(32'h0000_0048, OP_NONE, 1'b1);
		dec(32'h4400_0000, OP_FP_MOVE_FROM, 1'b0);
		dec(32'h4440_0000, OP_FP_CONTROL_FROM, 1'b0);
		dec(32'h4460_0000, OP_FP_MOVE_FROM_HIGH, 1'b0);
		dec(32'h4480_0000, OP_FP_MOVE_TO, 1'b0);
		dec(32'h44C0_0000, OP_FP_CONTROL_TO, 1'b0);
		dec(32'h44E0_0000, OP_FP_MOVE_TO_HIGH, 1'b0);
		dec(32'h4420_0000, OP_NONE, 1'b1);
		dec(32'h44A0_0000, OP_NONE, 1'b1);
		dec(32'h4620_0000, OP_FMT_DOUBLE, 1'b0);
		dec(32'h4680_0000, OP_FMT_WORD, 1'b0);
		dec(32'h46A0_0000, OP_FMT_LONG, 1'b0);
		dec(32'h46C0_0000, OP_FMT_PAIRED_SINGLE, 1'b0);
		dec(32'h4640_0000, OP_NONE, 1'b1);
		dec(32'h4660_0000, OP_NONE, 1'b1);
		dec(32'h46E0_0000, OP_NONE, 1'b1);
		dec(32'h4700_0000, OP_NONE, 1'b1);
		for (int i = 0; i < 8; i++)
			dec(32'h4600_0030 + 2 * i, sfd_op_t'(OP_FP_CMP_F + i), 1'b0);
		dec(32'h4600_0031, OP_NONE, 1'b1);
		dec(32'h4600_0028, OP_NONE, 1'b1);
		dec(32'h4600_0011, OP_FP_MOVE_IF_COND_FALSE, 1'b0);
		dec(32'h4601_0011, OP_FP_MOVE_IF_COND_TRUE, 1'b0);
		dec(32'h4200_0008, OP_TRANSLATION_BUFFER_PROBE, 1'b0);
		dec(32'h4200_0018, OP_EXCEPTION_RETURN, 1'b0);
		dec(32'h4200_0020, OP_WAIT_FOR_INTERRUPT, 1'b0);
		dec(32'h4200_0001, OP_NONE, 1'b1);
		cmp_cls(dcls, CLS_SYSTEM_COPROCESSOR);
		dec(32'h4000_0000, OP_PASS, 1'b0);
		dec(32'h7C00_0000, OP_PASS, 1'b0);
		cmp_cls(dcls, CLS_EXT);
		dec(32'h4500_0000, OP_PASS, 1'b0);
		cmp_cls(dcls, CLS_FLOATING_POINT_COPROCESSOR);
		dec(32'h2000_0000, OP_PASS, 1'b0);
		cmp_cls(dcls, CLS_OTHER);
		test_done("second release");
		mode(32'h3);
		dec(32'h7C00_0060, OP_NONE, 1'b1);
		mode(32'h0);
		dec(32'h0020_0002, OP_SHIFT_RIGHT_LOGICAL, 1'b0);
		dec(32'h0000_0046, OP_SHIFT_RIGHT_LOGICAL_VARIABLE, 1'b0);
		dec(32'h7C00_0420, OP_NONE, 1'b1);
		dec(32'h7C00_0000, OP_NONE, 1'b1);
		dec(32'h4160_0000, OP_NONE, 1'b1);
		dec(32'h4460_0000, OP_NONE, 1'b1);
		dec(32'h0000_00C0, OP_SHIFT_LEFT_LOGICAL, 1'b0);
		test_done("first release");
		for (int m = 0; m < 2; m++)
		begin
			mode(32'(m));
			for (int i = 0; i < 8; i++)
			begin
				seed = xs(seed);
				w = (seed & 32'h003F_FFC0) | 32'h2;
				dec(w, shr_exp(w, rel2), 1'b0);
				seed = xs(seed);
				w = 32'h4600_0000 | (seed & 32'h001F_FFC7);
				dec(w, fp_exp(w), 1'b0);
			end
		end
		test_done("random");
		mode(32'h1);
		bus(1'b1, 32'h8, 32'h0);
		bus(1'b1, 32'hC, 32'h0);
		dec(32'h4600_0028, OP_NONE, 1'b1);
		dec(32'h0000_0040, OP_SUPERSCALAR_NO_OPERATION, 1'b0);
		bus(1'b1, 32'h4, 32'hFFFF_FFFF);
		bus(1'b0, 32'h4, 32'h0);
		cmp32(rd, {19'h0, 3'(CLS_SPECIAL), 4'h0, 6'(OP_SUPERSCALAR_NO_OPERATION)});
		bus(1'b0, 32'h8, 32'h0);
		cmp32(rd, 32'h2);
		bus(1'b0, 32'hC, 32'h0);
		cmp32(rd, 32'h1);
		mode(32'h0);
		reset();
		bus(1'b0, 32'h0, 32'h0);
		cmp32(rd, 32'h1);
		bus(1'b0, 32'h8, 32'h0);
		cmp32(rd, 32'h0);
		dec(32'h0020_0002, OP_ROTATE_RIGHT, 1'b0);
		test_done("counters and reset");
		stop_test();
	end
endmodule

/* File: rtl/sfd_fp_dec.sv */
`include "sfd_map.svh"
module sfd_fp_dec
	import sfd_pkg::*;
(
	// Instruction and mode
	input  wire logic [31:0] instr,
	input  wire logic        release2,
	// Decoded result
	output sfd_op_t          op,
	output logic             reserved
);
	function automatic sfd_op_t arith(input logic [2:0] col);
		sfd_op_t r;
		r = OP_FP_ADD;
		unique case (col)
			3'h0: r = OP_FP_ADD;
			3'h1: r = OP_FP_SUB;
			3'h2: r = OP_FP_MUL;
			3'h3: r = OP_FP_DIV;
			3'h4: r = OP_FP_SQRT;
			3'h5: r = OP_FP_ABS;
			3'h6: r = OP_FP_MOV;
			3'h7: r = OP_FP_NEG;
		endcase
		return r;
	endfunction

	function automatic sfd_op_t compare(input logic [2:0] sel);
		sfd_op_t r;
		r = OP_FP_CMP_F;
		unique case (sel)
			3'h0: r = OP_FP_CMP_F;
			3'h1: r = OP_FP_CMP_UN;
			3'h2: r = OP_FP_CMP_EQ;
			3'h3: r = OP_FP_CMP_UEQ;
			3'h4: r = OP_FP_CMP_SF;
			3'h5: r = OP_FP_CMP_NGLE;
			3'h6: r = OP_FP_CMP_SEQ;
			3'h7: r = OP_FP_CMP_NGL;
		endcase
		return r;
	endfunction

	logic [1:0] row;
	logic [2:0] col;
	logic [5:0] fn;
	sfd_op_t    xfer_op;
	sfd_op_t    fmt_op;
	sfd_op_t    s_op;
	logic       xfer_rsv;
	logic       fmt_rsv;
	logic       s_rsv;
	logic       is_single;

	assign row = instr[25:24];
	assign col = instr[23:21];
	assign fn = instr[5:0];
	assign xfer_op =
		(col == 3'h0) ? OP_FP_MOVE_FROM :                              //RULE12
		(col == 3'h2) ? OP_FP_CONTROL_FROM :
		(col == 3'h3) ? OP_FP_MOVE_FROM_HIGH :
		(col == 3'h4) ? OP_FP_MOVE_TO :
		(col == 3'h6) ? OP_FP_CONTROL_TO :
		OP_FP_MOVE_TO_HIGH;
	assign xfer_rsv = (col == 3'h1) || (col == 3'h5) ||                //RULE12
		(!release2 && (col == 3'h3 || col == 3'h7));                   //RULE18
	assign fmt_op =
		(col == 3'h1) ? OP_FMT_DOUBLE :                                //RULE13
		(col == 3'h4) ? OP_FMT_WORD :
		(col == 3'h5) ? OP_FMT_LONG :
		OP_FMT_PAIRED_SINGLE;
	assign fmt_rsv = (col == 3'h2) || (col == 3'h3) || (col == 3'h7);  //RULE13
	assign is_single = (col == 3'h0);
	assign s_rsv = (fn[5:4] == 2'b11 && fn[0]) ||                      //RULE19
		(fn[5:3] == 3'b101) || (fn == 6'h10) || (fn == 6'h14) ||       //RULE17
		(fn[5:3] == 3'b011 && fn[2:0] != 3'h4 && fn[2:0] != 3'h5 &&
		fn[2:0] != 3'h6);
	assign s_op =
		(fn[5:3] == 3'b000) ? arith(fn[2:0]) :                         //RULE14
		(fn[5:4] == 2'b11) ? compare({fn[3], fn[2:1]}) :               //RULE15
		(fn == `SFD_FN_FP_MOVCF) ?                                     //RULE20
			(instr[`SFD_BIT_TF] ? OP_FP_MOVE_IF_COND_TRUE :             //RULE5
			OP_FP_MOVE_IF_COND_FALSE) :
		OP_PASS;
	assign reserved =
		(row == 2'h0) ? xfer_rsv :
		(row == 2'h1) ? (col != 3'h0) :                                //RULE19
		(row == 2'h2) ? (is_single ? s_rsv : fmt_rsv) :
		1'b1;                                                          //RULE19
	assign op =
		reserved ? OP_NONE :                                           //RULE21
		(row == 2'h0) ? xfer_op :
		(row == 2'h1) ? OP_PASS :
		is_single ? s_op : fmt_op;
endmodule

/* File: rtl/sfd_map.svh */
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH
// Function
// RULE1: Logical right shift: bit 21 low shifts, bit 21 high rotates right.
// RULE2: In first-release mode bit 21 is ignored; always plain logical shift.
// RULE3: Variable right shift: bit 6 low shifts, bit 6 high rotates right.
// RULE4: In first-release mode bit 6 is ignored; always plain variable shift.
// RULE5: Conditional move: bit 16 low moves if false, high moves if true.
// RULE6: Extended-function class decodes only in second release, else reserved.
// RULE7: Extended function row 100 column 000 is the byte-shuffle class.
// RULE8: Byte shuffle picks swap, sign-extend byte or halfword by shift field.
// RULE9: Interrupt-control function: bit 5 low disables, high enables.
// RULE10: rt, rd and shift field split shift-left, nop, superscalar_no_operation, barrier, pause.
// RULE11: Hint field splits register jumps from their hazard-barrier variants.
// RULE12: FP rs row 0 selects the six register transfers; 001 and 101 reserved.
// RULE13: FP rs row 2 selects operand format; columns 010, 011, 111 reserved.
// RULE14: Single format, function row 000 selects eight arithmetic operations.
// RULE15: Single format, rows 110 and 111 even columns select compares.
// RULE16: Coprocessor-op functions: probe 001000, return 011000, wait 100000.
// RULE17: Codes reserved for future use raise a reserved-instruction signal.
// RULE18: Codes valid only for newer levels raise a reserved-instruction signal.
// RULE19: Codes of unimplemented optional extensions raise reserved-instruction.
// RULE20: A field-class code is resolved by decoding a further field.
// RULE21: Each word yields exactly one operation or the reserved indication.
`define SFD_OPC_SPECIAL   6'h00
`define SFD_OPC_SYSTEM_COPROCESSOR      6'h10
`define SFD_OPC_FLOATING_POINT_COPROCESSOR      6'h11
`define SFD_OPC_EXT       6'h1F
`define SFD_FN_SHL        6'h00
`define SFD_FN_MOVE_COND  6'h01
`define SFD_FN_SHR        6'h02
`define SFD_FN_SHRV       6'h06
`define SFD_FN_JUMP_REG   6'h08
`define SFD_FN_JUMP_LINK  6'h09
`define SFD_SA_SUPERSCALAR_NO_OPERATION      5'h01
`define SFD_SA_BARRIER    5'h03
`define SFD_SA_PAUSE      5'h05
`define SFD_HINT_BARRIER  5'h10
`define SFD_BIT_ROT_IMM   21
`define SFD_BIT_ROT_VAR   6
`define SFD_BIT_TF        16
`define SFD_BIT_IE        5
`define SFD_FN_EXTRACT    6'h00
`define SFD_FN_INSERT     6'h04
`define SFD_FN_SHUFFLE    6'h20
`define SFD_SA_SWAP       5'h02
`define SFD_SA_SEXT_B     5'h10
`define SFD_SA_SEXT_H     5'h18
`define SFD_RS_C0_MOVE_FR 5'h00
`define SFD_RS_C0_MOVE_TO 5'h04
`define SFD_RS_C0_INTCTL  5'h0B
`define SFD_FN_PROBE      6'h08
`define SFD_FN_RETURN     6'h18
`define SFD_FN_WAIT       6'h20
`define SFD_FN_FP_MOVCF   6'h11
`define SFD_REG_CTRL      32'h0000_0000
`define SFD_REG_LAST      32'h0000_0004
`define SFD_REG_DEC_CNT   32'h0000_0008
`define SFD_REG_RSV_CNT   32'h0000_000C
`define SFD_CTRL_REL2     0
`define SFD_CTRL_STRICT   1
`define SFD_CTRL_MASK     32'h0000_0003
`define SFD_CTRL_RESET    32'h0000_0001
`define SFD_LAST_RSV      8
`endif

/* File: rtl/sfd_pkg.sv */
package sfd_pkg;
	typedef enum logic [5:0] {
		OP_NONE, OP_PASS,
		OP_SHIFT_LEFT_LOGICAL, OP_NO_OPERATION, OP_SUPERSCALAR_NO_OPERATION,
		OP_EXECUTION_HAZARD_BARRIER, OP_PAUSE,
		OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_RIGHT,
		OP_SHIFT_RIGHT_LOGICAL_VARIABLE, OP_ROTATE_RIGHT_VARIABLE,
		OP_MOVE_IF_COND_FALSE, OP_MOVE_IF_COND_TRUE,
		OP_JUMP_REGISTER, OP_JUMP_REGISTER_HAZARD_BARRIER,
		OP_JUMP_LINK_REGISTER, OP_JUMP_LINK_REGISTER_BARRIER,
		OP_SWAP_BYTES_IN_HALFWORDS, OP_SIGN_EXTEND_BYTE, OP_SIGN_EXTEND_HALFWORD,
		OP_DISABLE_INTERRUPTS, OP_ENABLE_INTERRUPTS,
		OP_TRANSLATION_BUFFER_PROBE, OP_EXCEPTION_RETURN, OP_WAIT_FOR_INTERRUPT,
		OP_FP_MOVE_FROM, OP_FP_CONTROL_FROM, OP_FP_MOVE_FROM_HIGH,
		OP_FP_MOVE_TO, OP_FP_CONTROL_TO, OP_FP_MOVE_TO_HIGH,
		OP_FMT_DOUBLE, OP_FMT_WORD, OP_FMT_LONG, OP_FMT_PAIRED_SINGLE,
		OP_FP_ADD, OP_FP_SUB, OP_FP_MUL, OP_FP_DIV,
		OP_FP_SQRT, OP_FP_ABS, OP_FP_MOV, OP_FP_NEG,
		OP_FP_CMP_F, OP_FP_CMP_UN, OP_FP_CMP_EQ, OP_FP_CMP_UEQ,
		OP_FP_CMP_SF, OP_FP_CMP_NGLE, OP_FP_CMP_SEQ, OP_FP_CMP_NGL,
		OP_FP_MOVE_IF_COND_FALSE, OP_FP_MOVE_IF_COND_TRUE
	} sfd_op_t;

	typedef enum logic [2:0] {
		CLS_OTHER, CLS_SPECIAL, CLS_EXT, CLS_SYSTEM_COPROCESSOR, CLS_FLOATING_POINT_COPROCESSOR
	} sfd_class_t;
endpackage

/* File: rtl/sfd_special_dec.sv */
`include "sfd_map.svh"
module sfd_special_dec
	import sfd_pkg::*;
(
	// Instruction and mode
	input  wire logic [31:0] instr,
	input  wire logic        release2,
	// Decoded result
	output sfd_op_t          op,
	output logic             reserved
);
	logic [5:0] fn;
	logic [4:0] sa;
	logic       zero_regs;
	logic       hint_ok;
	logic       hint_hb;
	sfd_op_t    shl_op;
	sfd_op_t    jr_op;
	sfd_op_t    jl_op;

	assign fn = instr[5:0];
	assign sa = instr[10:6];
	assign zero_regs = (instr[20:11] == 10'h000);
	assign shl_op =
		(zero_regs && sa == 5'h00) ? OP_NO_OPERATION :                //RULE10
		(zero_regs && sa == `SFD_SA_SUPERSCALAR_NO_OPERATION) ? OP_SUPERSCALAR_NO_OPERATION :
		(zero_regs && release2 && sa == `SFD_SA_BARRIER) ?
			OP_EXECUTION_HAZARD_BARRIER :
		(zero_regs && release2 && sa == `SFD_SA_PAUSE) ? OP_PAUSE :
		OP_SHIFT_LEFT_LOGICAL;
	assign hint_hb = release2 && (sa == `SFD_HINT_BARRIER);            //RULE18
	assign hint_ok = (sa == 5'h00) || hint_hb;
	assign jr_op = hint_hb ? OP_JUMP_REGISTER_HAZARD_BARRIER :         //RULE11
		OP_JUMP_REGISTER;
	assign jl_op = hint_hb ? OP_JUMP_LINK_REGISTER_BARRIER :           //RULE11
		OP_JUMP_LINK_REGISTER;
	assign reserved = ((fn == `SFD_FN_JUMP_REG) || (fn == `SFD_FN_JUMP_LINK))
		&& !hint_ok;                                                   //RULE17
	assign op =
		reserved ? OP_NONE :                                           //RULE21
		(fn == `SFD_FN_SHL) ? shl_op :
		(fn == `SFD_FN_SHR) ?
			((release2 && instr[`SFD_BIT_ROT_IMM]) ? OP_ROTATE_RIGHT : //RULE1 RULE2
			OP_SHIFT_RIGHT_LOGICAL) :
		(fn == `SFD_FN_SHRV) ?
			((release2 && instr[`SFD_BIT_ROT_VAR]) ?                   //RULE3 RULE4
			OP_ROTATE_RIGHT_VARIABLE : OP_SHIFT_RIGHT_LOGICAL_VARIABLE) :
		(fn == `SFD_FN_MOVE_COND) ?
			(instr[`SFD_BIT_TF] ? OP_MOVE_IF_COND_TRUE :                //RULE5
			OP_MOVE_IF_COND_FALSE) :
		(fn == `SFD_FN_JUMP_REG) ? jr_op :
		(fn == `SFD_FN_JUMP_LINK) ? jl_op :
		OP_PASS;
endmodule

/* File: rtl/sfd_top.sv */
`include "sfd_map.svh"
module sfd_top
	import sfd_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Instruction from fetch and issue
	input  wire logic        INSTR_VALID,
	input  wire logic [31:0] INSTR_WORD,
	// Decoded result
	output logic             DEC_VALID,
	output sfd_op_t          DEC_OP,
	output logic             DEC_RESERVED,
	output sfd_class_t       DEC_CLASS
);
	logic        rst_q1;
	logic        rst_n;
	logic [31:0] ctrl;
	logic [31:0] last;
	logic [31:0] dec_cnt;
	logic [31:0] rsv_cnt;
	logic        wr_pend;
	logic [31:0] wr_addr;

	// Reset release
	always_ff @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Mode bits
	logic release2;
	logic strict;
	assign release2 = ctrl[`SFD_CTRL_REL2];
	assign strict = ctrl[`SFD_CTRL_STRICT];

	// Instruction fields
	logic [5:0] opcode;
	logic [5:0] fn;
	logic [4:0] rs;
	logic [4:0] sa;
	assign opcode = INSTR_WORD[31:26];
	assign fn = INSTR_WORD[5:0];
	assign rs = INSTR_WORD[25:21];
	assign sa = INSTR_WORD[10:6];

	// Plain function class
	sfd_op_t sp_op;
	logic    sp_rsv;
	sfd_special_dec u_special (
		.instr    (INSTR_WORD),
		.release2 (release2),
		.op       (sp_op),
		.reserved (sp_rsv)
	);

	// Floating-point coprocessor
	sfd_op_t fp_op;
	logic    fp_rsv;
	sfd_fp_dec u_fp (
		.instr    (INSTR_WORD),
		.release2 (release2),
		.op       (fp_op),
		.reserved (fp_rsv)
	);

	// Extended-function class and byte shuffle
	logic    shuf_hit;
	logic    shuf_known;
	sfd_op_t shuf_op;
	logic    ext_rsv;
	sfd_op_t ext_op;
	assign shuf_hit = (fn == `SFD_FN_SHUFFLE);                         //RULE7
	assign shuf_known = (sa == `SFD_SA_SWAP) || (sa == `SFD_SA_SEXT_B) ||
		(sa == `SFD_SA_SEXT_H);
	assign shuf_op =
		(sa == `SFD_SA_SWAP) ? OP_SWAP_BYTES_IN_HALFWORDS :            //RULE8
		(sa == `SFD_SA_SEXT_B) ? OP_SIGN_EXTEND_BYTE :
		(sa == `SFD_SA_SEXT_H) ? OP_SIGN_EXTEND_HALFWORD :
		OP_NO_OPERATION;
	assign ext_rsv = !release2 ||                                      //RULE6
		(shuf_hit && !shuf_known && strict) ||                         //RULE8
		(!shuf_hit && fn != `SFD_FN_EXTRACT && fn != `SFD_FN_INSERT);  //RULE19
	assign ext_op =
		ext_rsv ? OP_NONE :
		shuf_hit ? shuf_op :                                           //RULE20
		OP_PASS;

	// System coprocessor
	logic    c0_cop;
	logic    c0_int;
	logic    c0_rsv;
	sfd_op_t c0_func_op;
	sfd_op_t c0_op;
	assign c0_cop = INSTR_WORD[25];
	assign c0_int = (rs == `SFD_RS_C0_INTCTL);
	assign c0_func_op =
		(fn == `SFD_FN_PROBE) ? OP_TRANSLATION_BUFFER_PROBE :          //RULE16
		(fn == `SFD_FN_RETURN) ? OP_EXCEPTION_RETURN :
		(fn == `SFD_FN_WAIT) ? OP_WAIT_FOR_INTERRUPT :
		OP_NONE;
	assign c0_rsv =
		c0_cop ? (c0_func_op == OP_NONE) :                             //RULE17
		c0_int ? !release2 :                                           //RULE18
		!(rs == `SFD_RS_C0_MOVE_FR || rs == `SFD_RS_C0_MOVE_TO);
	assign c0_op =
		c0_rsv ? OP_NONE :
		c0_cop ? c0_func_op :
		c0_int ? (INSTR_WORD[`SFD_BIT_IE] ? OP_ENABLE_INTERRUPTS :      //RULE9
			OP_DISABLE_INTERRUPTS) :
		OP_PASS;

	// Class selection
	sfd_class_t cls;
	sfd_op_t    sel_op;
	logic       sel_rsv;
	assign cls =
		(opcode == `SFD_OPC_SPECIAL) ? CLS_SPECIAL :
		(opcode == `SFD_OPC_EXT) ? CLS_EXT :
		(opcode == `SFD_OPC_SYSTEM_COPROCESSOR) ? CLS_SYSTEM_COPROCESSOR :
		(opcode == `SFD_OPC_FLOATING_POINT_COPROCESSOR) ? CLS_FLOATING_POINT_COPROCESSOR :
		CLS_OTHER;
	assign sel_rsv =
		(cls == CLS_SPECIAL) ? sp_rsv :
		(cls == CLS_EXT) ? ext_rsv :
		(cls == CLS_SYSTEM_COPROCESSOR) ? c0_rsv :
		(cls == CLS_FLOATING_POINT_COPROCESSOR) ? fp_rsv :
		1'b0;
	assign sel_op =
		sel_rsv ? OP_NONE :                                            //RULE21
		(cls == CLS_SPECIAL) ? sp_op :
		(cls == CLS_EXT) ? ext_op :
		(cls == CLS_SYSTEM_COPROCESSOR) ? c0_op :
		(cls == CLS_FLOATING_POINT_COPROCESSOR) ? fp_op :
		OP_PASS;

	// Decoded result registers
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			DEC_VALID <= 1'b0;
			DEC_OP <= OP_NONE;
			DEC_RESERVED <= 1'b0;
			DEC_CLASS <= CLS_OTHER;
		end
		else
		begin
			DEC_VALID <= INSTR_VALID;
			if (INSTR_VALID)
			begin
				DEC_OP <= sel_op;
				DEC_RESERVED <= sel_rsv;
				DEC_CLASS <= cls;
			end
		end
	end

	// Bus address phase
	logic accept;
	logic rd_accept;
	assign accept = HSEL && HREADY && HTRANS[1];
	assign rd_accept = accept && !HWRITE;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	function automatic logic [31:0] reg_read(input logic [31:0] a,
		input logic [31:0] c, input logic [31:0] l,
		input logic [31:0] d, input logic [31:0] r);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == `SFD_REG_CTRL)
			v = c;
		else if (a == `SFD_REG_LAST)
			v = l;
		else if (a == `SFD_REG_DEC_CNT)
			v = d;
		else if (a == `SFD_REG_RSV_CNT)
			v = r;
		return v;
	endfunction

	logic [31:0] rd_value;
	assign rd_value = reg_read(HADDR, ctrl, last, dec_cnt, rsv_cnt);

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
			HRDATA <= 32'h0000_0000;
		end
		else
		begin
			wr_pend <= accept && HWRITE;
			if (accept)
				wr_addr <= HADDR;
			if (rd_accept)
				HRDATA <= rd_value;
		end
	end

	// Bus data phase writes
	logic wr_ctrl;
	logic clr_dec;
	logic clr_rsv;
	logic ev_rsv;
	logic [31:0] next_last;
	logic [31:0] next_dec_cnt;
	logic [31:0] next_rsv_cnt;
	assign wr_ctrl = wr_pend && (wr_addr == `SFD_REG_CTRL);
	assign clr_dec = wr_pend && (wr_addr == `SFD_REG_DEC_CNT);
	assign clr_rsv = wr_pend && (wr_addr == `SFD_REG_RSV_CNT);
	assign ev_rsv = INSTR_VALID && sel_rsv;
	assign next_last = {19'h00000, cls, 1'b0, sel_rsv, 2'b00, sel_op};
	assign next_dec_cnt = clr_dec ? {31'h0, INSTR_VALID} :
		dec_cnt + {31'h0, INSTR_VALID};
	assign next_rsv_cnt = clr_rsv ? {31'h0, ev_rsv} :
		rsv_cnt + {31'h0, ev_rsv};

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= `SFD_CTRL_RESET;
			last <= 32'h0000_0000;
			dec_cnt <= 32'h0000_0000;
			rsv_cnt <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= HWDATA & `SFD_CTRL_MASK;
			if (INSTR_VALID)
				last <= next_last;
			dec_cnt <= next_dec_cnt;
			rsv_cnt <= next_rsv_cnt;
		end
	end
endmodule
